// *** hdl/rwt_pkg.sv ***
// Functional notes
// R01: Down-counter auto-reloads, periodic events while enabled.
// R02: Zero reach sets flag; interrupt if enabled.
// R03: Logic stays running on kernel clock always.
// R04: Wakeup event optionally drives alarm pad, polarity.
// R05: Key 0xCA then 0x53 unlocks protected registers.
// R06: Key 0xFF relocks; protected writes then ignored.
// R07: Clear enable before changing reload or select.
// R08: Write-allowed flag sets two cycles after disable.
// R09: Sixteen-bit reload value in reload register.
// R10: Setting enable restarts count from reload value.
// R11: Select 0xx ticks kernel clock over 16/8/4/2.
// R12: Select 10x ticks on calendar prescaler output.
// R13: Select 11x adds 0x10000 to reload value.
// R14: Period is effective reload plus one ticks.
// R15: Zero reload with select 011 is prohibited.
// R16: Flag stays set until software clears it.
package rwt_pkg;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFF_KEY    = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_STAT   = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_RELOAD = 4'hC;
    localparam logic [7:0] KEY_FIRST = 8'hCA;
    localparam logic [7:0] KEY_SECOND = 8'h53;
    localparam logic [7:0] KEY_LOCK = 8'hFF;
    // Control register fields.
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_EN_BIT = 3;
    localparam int CTRL_OUT_EN_BIT = 4;
    localparam int CTRL_POL_BIT = 5;
    // Status register: bit 0 wakeup flag, bit 1 write allowed,
    // bit 2 unlocked; interrupt mask sits at bit 8.
    localparam int STAT_FLAG_BIT = 0;
    localparam int STAT_WA_BIT = 1;
    localparam int STAT_UNLK_BIT = 2;
    localparam int STAT_MASK_BIT = 8;
    localparam logic [15:0] RELOAD_RST = 16'hFFFF;
    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic [16:0] EXT_OFFSET = 17'h10000;
    localparam int WA_DELAY = 2;
    localparam logic [1:0] WA_DELAY_CNT = 2'(WA_DELAY);

    typedef enum logic [1:0] {
        RWT_LOCKED,
        RWT_HALF,
        RWT_OPEN
    } rwt_key_t;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [31:0]       writedata;
        logic [3:0]        byteenable;
    } rwt_bus_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } rwt_bus_rsp_t;
endpackage

// *** hdl/rwt_tick_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module rwt_tick_gen
    import rwt_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    input  wire logic       run_i,
    input  wire logic [2:0] sel_i,
    input  wire logic       cal_tick_i,
    output logic            tick_o
);
    typedef struct packed {
        logic [3:0] div;
        logic       tick;
    } rwt_tick_st_t;

    rwt_tick_st_t st_r;
    rwt_tick_st_t st_nxt;
    logic [3:0]   top;

    always_comb begin
        st_nxt = st_r;
        top = 4'hF >> sel_i[1:0]; // R11
        st_nxt.tick = 1'b0;
        if (!run_i) begin
            st_nxt.div = 4'h0;
        end else if (sel_i[2]) begin
            st_nxt.tick = cal_tick_i; // R12
        end else if (st_r.div >= top) begin
            st_nxt.div = 4'h0;
            st_nxt.tick = 1'b1; // R11
        end else begin
            st_nxt.div = st_r.div + 4'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_o = st_r.tick;
endmodule
`default_nettype wire

// *** hdl/rwt_wakeup_timer.sv ***
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rwt_wakeup_timer
    import rwt_pkg::*;
(
    input  wire logic                 mclk_i,
    input  wire logic                 rstn_i,
    input  wire rwt_pkg::rwt_bus_req_t bus_req_i,
    input  wire logic                 cal_tick_i,
    output rwt_pkg::rwt_bus_rsp_t     bus_rsp_o,
    output logic                      irq_o,
    output logic                      alarm_pad_o
);
    import rwt_pkg::*;

    typedef struct packed {
        rwt_key_t     key;
        logic         en;
        logic [2:0]   sel;
        logic         out_en;
        logic         pol;
        logic [15:0]  reload;
        logic [16:0]  cnt;
        logic         flag;
        logic         mask;
        logic         wa;
        logic [1:0]   wa_cnt;
        logic         ack;
        logic [31:0]  rdata;
        logic         irq;
        logic         pad;
    } rwt_state_t;

    rwt_state_t st_r;
    rwt_state_t st_nxt;
    logic       tick;
    logic       zero_evt;
    logic       wr;
    logic       rd;
    logic       prot_ok;

    function automatic logic [16:0] eff_reload(input logic [2:0] s,
                                               input logic [15:0] v);
        eff_reload = s[2] & s[1] ? EXT_OFFSET + {1'b0, v}
                                 : {1'b0, v}; // R13
    endfunction

    // Runs on the kernel clock, which is kept alive in low power. R03
    rwt_tick_gen u_tick (
        .mclk_i     (mclk_i),
        .rstn_i     (rstn_i),
        .run_i      (st_r.en),
        .sel_i      (st_r.sel),
        .cal_tick_i (cal_tick_i),
        .tick_o     (tick)
    );

    // One wait cycle per access: read data is captured in the request
    // cycle, and a write lands at the edge that ends the answer cycle,
    // which is the edge at which the master sees waitrequest low.
    assign wr = bus_req_i.write & st_r.ack;
    assign rd = bus_req_i.read & ~st_r.ack;
    assign prot_ok = (st_r.key == RWT_OPEN);
    assign zero_evt = st_r.en & tick & (st_r.cnt == 17'h0);

    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = (bus_req_i.write | bus_req_i.read) & ~st_r.ack;
        // Count to zero, then reload: period is effective reload plus one ticks.
        if (st_r.en && tick) begin
            if (st_r.cnt == 17'h0) begin
                st_nxt.cnt = eff_reload(st_r.sel, st_r.reload); // R01 R14
            end else begin
                st_nxt.cnt = st_r.cnt - 17'h1;
            end
        end
        // The write-allowed flag is the inverse of the enable, with a short lag.
        if (st_r.en) begin
            st_nxt.wa = 1'b0;
            st_nxt.wa_cnt = 2'h0;
        end else if (!st_r.wa) begin
            if (st_r.wa_cnt == WA_DELAY_CNT - 2'h1) begin
                st_nxt.wa = 1'b1; // R08
            end else begin
                st_nxt.wa_cnt = st_r.wa_cnt + 2'h1;
            end
        end
        if (wr && bus_req_i.byteenable[0]) begin
            case (bus_req_i.address)
                OFF_KEY: begin
                    if (bus_req_i.writedata[7:0] == KEY_LOCK) begin
                        st_nxt.key = RWT_LOCKED; // R06
                    end else if (st_r.key != RWT_OPEN &&
                                 bus_req_i.writedata[7:0] == KEY_FIRST) begin
                        st_nxt.key = RWT_HALF; // R05
                    end else if (st_r.key == RWT_HALF &&
                                 bus_req_i.writedata[7:0] == KEY_SECOND) begin
                        st_nxt.key = RWT_OPEN; // R05
                    end else if (st_r.key != RWT_OPEN) begin
                        st_nxt.key = RWT_LOCKED;
                    end
                end
                OFF_CTRL: begin
                    if (prot_ok) begin // R05 R06
                        // Select only changes while the counter is
                        // stopped and the flag is up. R07
                        if (st_r.wa) begin
                            st_nxt.sel = bus_req_i.writedata[
                                CTRL_SEL_LSB+:3];
                        end
                        st_nxt.en = bus_req_i.writedata[CTRL_EN_BIT];
                        st_nxt.out_en = bus_req_i.writedata[CTRL_OUT_EN_BIT];
                        st_nxt.pol = bus_req_i.writedata[CTRL_POL_BIT];
                        if (bus_req_i.writedata[CTRL_EN_BIT] && !st_r.en) begin
                            st_nxt.cnt = eff_reload(st_nxt.sel,
                                                    st_r.reload); // R10
                        end
                    end
                end
                OFF_STAT: begin
                    if (bus_req_i.writedata[STAT_FLAG_BIT]) begin
                        st_nxt.flag = 1'b0; // R16
                    end
                end
                OFF_RELOAD: begin
                    if (prot_ok && st_r.wa) begin // R07 R09
                        st_nxt.reload = bus_req_i.writedata[15:0];
                    end
                end
                default: begin
                end
            endcase
        end
        if (wr && bus_req_i.byteenable[1] &&
            bus_req_i.address == OFF_STAT) begin
            st_nxt.mask = bus_req_i.writedata[STAT_MASK_BIT];
        end
        // Set beats clear in the same cycle.
        if (zero_evt) begin
            st_nxt.flag = 1'b1; // R02 R16
        end
        st_nxt.irq = st_nxt.flag & st_nxt.mask; // R02
        st_nxt.pad = (st_nxt.out_en & st_nxt.flag) ^ st_nxt.pol; // R04
        st_nxt.rdata = 32'h0;
        if (rd) begin
            case (bus_req_i.address)
                OFF_CTRL: begin
                    st_nxt.rdata[CTRL_SEL_LSB+:3] = st_r.sel;
                    st_nxt.rdata[CTRL_EN_BIT] = st_r.en;
                    st_nxt.rdata[CTRL_OUT_EN_BIT] = st_r.out_en;
                    st_nxt.rdata[CTRL_POL_BIT] = st_r.pol;
                end
                OFF_STAT: begin
                    st_nxt.rdata[STAT_FLAG_BIT] = st_r.flag;
                    st_nxt.rdata[STAT_WA_BIT] = st_r.wa;
                    st_nxt.rdata[STAT_UNLK_BIT] = prot_ok;
                    st_nxt.rdata[STAT_MASK_BIT] = st_r.mask;
                end
                OFF_RELOAD: begin
                    st_nxt.rdata[15:0] = st_r.reload;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            st_r <= '0;
            st_r.key <= RWT_LOCKED;
            st_r.sel <= SEL_RST;
            st_r.reload <= RELOAD_RST;
            st_r.wa <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus_rsp_o.readdata = st_r.rdata;
    assign bus_rsp_o.waitrequest = ~st_r.ack;
    assign irq_o = st_r.irq;
    assign alarm_pad_o = st_r.pad;

    property p_flag_on_zero;
        @(posedge mclk_i) disable iff (!rstn_i)
        zero_evt |=> st_r.flag;
    endproperty
    a_flag_on_zero: assert property (p_flag_on_zero) // R02
        else $error("Flag not set after zero reach.");

    property p_reload_after_zero;
        @(posedge mclk_i) disable iff (!rstn_i)
        zero_evt |=> st_r.cnt == eff_reload($past(st_r.sel),
                                            $past(st_r.reload));
    endproperty
    a_reload_after_zero: assert property (p_reload_after_zero) // R01
        else $error("Counter did not reload after zero.");

    property p_wa_delay;
        @(posedge mclk_i) disable iff (!rstn_i)
        $fell(st_r.en) ##1 !st_r.en |-> ##1 st_r.wa;
    endproperty
    a_wa_delay: assert property (p_wa_delay) // R08
        else $error("Write allowed flag late.");

    property p_wa_low_when_en;
        @(posedge mclk_i) disable iff (!rstn_i)
        $rose(st_r.en) |=> !st_r.wa;
    endproperty
    a_wa_low_when_en: assert property (p_wa_low_when_en) // R08
        else $error("Write allowed flag high while running.");

    property p_locked_ignore;
        @(posedge mclk_i) disable iff (!rstn_i)
        st_r.key != RWT_OPEN |=> $stable(st_r.reload) && $stable(st_r.en);
    endproperty
    a_locked_ignore: assert property (p_locked_ignore) // R06
        else $error("Protected register changed while locked.");

    property p_unlock;
        @(posedge mclk_i) disable iff (!rstn_i)
        wr && bus_req_i.byteenable[0] && bus_req_i.address == OFF_KEY &&
        st_r.key == RWT_HALF && bus_req_i.writedata[7:0] == KEY_SECOND
        |=> st_r.key == RWT_OPEN;
    endproperty
    a_unlock: assert property (p_unlock) // R05
        else $error("Key sequence did not unlock.");

    property p_restart;
        @(posedge mclk_i) disable iff (!rstn_i)
        $rose(st_r.en) |-> st_r.cnt == eff_reload(st_r.sel, st_r.reload);
    endproperty
    a_restart: assert property (p_restart) // R10
        else $error("Enable did not restart from reload.");

    property p_flag_sticky;
        @(posedge mclk_i) disable iff (!rstn_i)
        st_r.flag && !(wr && bus_req_i.address == OFF_STAT) |=> st_r.flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // R16
        else $error("Flag dropped without a clear.");

    property p_irq;
        @(posedge mclk_i) disable iff (!rstn_i)
        irq_o == (st_r.flag && st_r.mask);
    endproperty
    a_irq: assert property (p_irq) // R02
        else $error("Interrupt does not follow flag and mask.");

    property p_stop_hold;
        @(posedge mclk_i) disable iff (!rstn_i)
        !st_r.en && !$rose(st_r.en) ##1 !st_r.en |-> $stable(st_r.cnt);
    endproperty
    a_stop_hold: assert property (p_stop_hold) // R07
        else $error("Counter moved while disabled.");

    property p_pad;
        @(posedge mclk_i) disable iff (!rstn_i)
        st_r.flag && st_r.out_en |-> alarm_pad_o != st_r.pol;
    endproperty
    a_pad: assert property (p_pad) // R04
        else $error("Alarm pad not active with flag set.");

    property p_pad_idle;
        @(posedge mclk_i) disable iff (!rstn_i)
        !st_r.flag |-> alarm_pad_o == st_r.pol;
    endproperty
    a_pad_idle: assert property (p_pad_idle) // R04
        else $error("Alarm pad not idle with flag clear.");

    property p_count_down;
        @(posedge mclk_i) disable iff (!rstn_i)
        st_r.en && tick && st_r.cnt != 17'h0 |=>
            st_r.cnt == $past(st_r.cnt) - 17'h1;
    endproperty
    a_count_down: assert property (p_count_down) // R01
        else $error("Counter did not step down on a tick.");

    // Only the divide-by-two rate is checked here: a restart by a fast
    // master could land inside the longer gaps of the slower rates.
    property p_div2_rate;
        @(posedge mclk_i) disable iff (!rstn_i)
        st_r.en && tick && st_r.sel == 3'b011 |=>
            !tick ##1 (tick || !st_r.en);
    endproperty
    a_div2_rate: assert property (p_div2_rate) // R11
        else $error("Divide by two tick spacing wrong.");

    property p_cal_tick;
        @(posedge mclk_i) disable iff (!rstn_i)
        st_r.en && st_r.sel[2] && cal_tick_i |=> tick;
    endproperty
    a_cal_tick: assert property (p_cal_tick) // R12
        else $error("Calendar tick not passed to the counter.");

    property p_ext_restart;
        @(posedge mclk_i) disable iff (!rstn_i)
        $rose(st_r.en) && st_r.sel[2:1] == 2'b11 |->
            st_r.cnt == EXT_OFFSET + {1'b0, st_r.reload};
    endproperty
    a_ext_restart: assert property (p_ext_restart) // R13
        else $error("Extended range start value wrong.");

    property p_cfg_hold;
        @(posedge mclk_i) disable iff (!rstn_i)
        !st_r.wa |=> $stable(st_r.sel) && $stable(st_r.reload);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) // R07
        else $error("Select or reload changed while not allowed.");

    property p_reload_write;
        @(posedge mclk_i) disable iff (!rstn_i)
        wr && bus_req_i.byteenable[0] && bus_req_i.address == OFF_RELOAD &&
        prot_ok && st_r.wa |=>
            st_r.reload == $past(bus_req_i.writedata[15:0]);
    endproperty
    a_reload_write: assert property (p_reload_write) // R09
        else $error("Allowed reload write did not land.");

    property p_flag_clear;
        @(posedge mclk_i) disable iff (!rstn_i)
        wr && bus_req_i.byteenable[0] && bus_req_i.address == OFF_STAT &&
        bus_req_i.writedata[STAT_FLAG_BIT] && !zero_evt |=> !st_r.flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) // R16
        else $error("Flag not cleared by a one written.");

    property p_relock;
        @(posedge mclk_i) disable iff (!rstn_i)
        wr && bus_req_i.byteenable[0] && bus_req_i.address == OFF_KEY &&
        bus_req_i.writedata[7:0] == KEY_LOCK |=> st_r.key == RWT_LOCKED;
    endproperty
    a_relock: assert property (p_relock) // R06
        else $error("Lock key did not relock.");

    c_zero: cover property (@(posedge mclk_i) zero_evt);
    c_ext: cover property (@(posedge mclk_i)
        $rose(st_r.en) && st_r.sel[2:1] == 2'b11);
    c_irq: cover property (@(posedge mclk_i) $rose(irq_o));
    c_open: cover property (@(posedge mclk_i) $rose(prot_ok));
endmodule
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rwt_pkg::*;
    logic         mclk_i;
    logic         rstn_i;
    rwt_bus_req_t req;
    rwt_bus_rsp_t rsp;
    logic         cal_tick;
    logic         irq;
    logic         pad;
    int           n_fail;
    int           compares;
    int           cyc;
    int           last_rise;
    bit           skip;
    logic         prev_irq;
    logic         exp_pad;
    logic [31:0]  rd_exp[$];
    logic [31:0]  rd_msk[$];
    string        rd_nam[$];
    int           per_q[$];
    logic [31:0]  rdat;
    logic [31:0]  mask_w;
    logic [15:0]  nrel;
    logic [1:0]   op;
    int           i;
    int           dv;

    rwt_wakeup_timer DUT (
        .mclk_i      (mclk_i),
        .rstn_i      (rstn_i),
        .bus_req_i   (req),
        .cal_tick_i  (cal_tick),
        .bus_rsp_o   (rsp),
        .irq_o       (irq),
        .alarm_pad_o (pad)
    );

    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    task automatic summarize();
        $display("Compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Requests start right after an edge and are held until waitrequest
    // is sampled low, so the slave's latency is never assumed.
    task automatic bus(logic w, logic [3:0] a, logic [31:0] d,
                       logic [3:0] be);
        int k;
        req.address <= a;
        req.read <= ~w;
        req.write <= w;
        req.writedata <= d;
        req.byteenable <= be;
        for (k = 0; k < 50; k++) begin
            @(posedge mclk_i);
            if (rsp.waitrequest === 1'b0)
                break;
        end
        if (k == 50) begin
            n_fail++;
            summarize();
        end
        rdat = rsp.readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic wr(logic [3:0] a, logic [31:0] d, logic [3:0] be);
        bus(1'b1, a, d, be);
    endtask

    task automatic rd(logic [3:0] a, logic [31:0] e, logic [31:0] m,
                      string nm);
        rd_exp.push_back(e);
        rd_msk.push_back(m);
        rd_nam.push_back(nm);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask

    task automatic wait_irq(int lim);
        int k;
        for (k = 0; k < lim; k++) begin
            @(posedge mclk_i);
            if (irq === 1'b1)
                break;
        end
        if (k == lim) begin
            n_fail++;
            summarize();
        end
    endtask

    task automatic run(logic [2:0] s, logic [15:0] n, int per, int cnt);
        int k;
        wr(OFF_CTRL, {26'h0, op, 1'b0, s}, 4'hF);
        for (k = 0; k < 20; k++) begin
            bus(1'b0, OFF_STAT, 32'h0, 4'hF);
            if (rdat[STAT_WA_BIT] === 1'b1)
                break;
        end
        check("write allowed delay", 32'h1, 32'(k < 2));
        wr(OFF_STAT, mask_w | 32'h1, 4'h3);
        wr(OFF_RELOAD, {16'h0, n}, 4'hF);
        wr(OFF_CTRL, {26'h0, op, 1'b0, s}, 4'hF);
        skip = 1'b1;
        if (cnt > 0)
            per_q.push_back(per);
        wr(OFF_CTRL, {26'h0, op, 1'b1, s}, 4'hF);
        for (k = 0; k < cnt; k++) begin
            wait_irq(2 * per + 40);
            wr(OFF_STAT, mask_w | 32'h1, 4'h3);
            check("irq cleared", 32'h0, 32'(irq));
            check("pad idle", 32'(op[1]), 32'(pad));
        end
        if (cnt == 0) begin
            repeat (3 * per) @(posedge mclk_i);
            check("extended range irq", 32'h0, 32'(irq));
        end
    endtask

    // Watcher: takes the oldest note off a queue when a result shows.
    always @(posedge mclk_i) begin
        cal_tick <= (cyc % 3 == 0);
        if (rsp.waitrequest === 1'b0 && req.read === 1'b1 &&
            rd_exp.size() > 0) begin
            check(rd_nam[0], rd_exp[0], rsp.readdata & rd_msk[0]);
            void'(rd_exp.pop_front());
            void'(rd_msk.pop_front());
            void'(rd_nam.pop_front());
        end
        if (irq === 1'b1 && prev_irq !== 1'b1) begin
            check("alarm pad", 32'(exp_pad), 32'(pad));
            if (skip)
                skip = 1'b0;
            else if (per_q.size() > 0)
                check("period", per_q.pop_front(), cyc - last_rise);
            last_rise = cyc;
        end
        prev_irq = irq;
        cyc = cyc + 1;
    end

    initial begin
        req = '0;
        rstn_i = 1'b0;
        n_fail = 0;
        compares = 0;
        skip = 1'b1;
        mask_w = 32'h0;
        op = 2'h0;
        exp_pad = 1'b0;
        void'($urandom(32'hD82A));
        repeat (10) @(posedge mclk_i);
        rstn_i <= 1'b1;
        @(posedge mclk_i);
        rd(OFF_STAT, 32'h2, 32'h107, "status reset");
        rd(OFF_CTRL, 32'h0, 32'h3F, "control reset");
        rd(OFF_RELOAD, 32'hFFFF, 32'hFFFF, "reload reset");
        wr(OFF_CTRL, 32'h8, 4'hF);
        wr(4'h2, 32'h1, 4'hF);
        rd(4'h2, 32'h0, 32'hFFFFFFFF, "unmapped");
        rd(OFF_CTRL, 32'h0, 32'h3F, "locked control");
        wr(OFF_KEY, {24'h0, KEY_FIRST}, 4'h1);
        wr(OFF_KEY, {24'h0, KEY_SECOND}, 4'h1);
        rd(OFF_STAT, 32'h6, 32'h6, "unlocked");
        mask_w = 32'h100;
        wr(OFF_STAT, mask_w, 4'h2);
        // Every select code once; 11x only shows that no early event comes.
        for (i = 0; i < 8; i++) begin
            nrel = 16'(4 + $urandom_range(8));
            dv = i[2] ? 3 : (16 >> i[1:0]);
            op = 2'(i);
            exp_pad = ^op;
            run(3'(i), nrel, (nrel + 1) * dv, i < 6 ? 2 : 0);
            if (i == 5) begin
                mask_w = 32'h0;
                wr(OFF_STAT, 32'h1, 4'h3);
                repeat (3 * (nrel + 1) * dv) @(posedge mclk_i);
                check("masked irq", 32'h0, 32'(irq));
                rd(OFF_STAT, 32'h1, 32'h3, "sticky flag");
                wr(OFF_RELOAD, 32'h3, 4'hF);
                rd(OFF_RELOAD, 32'(nrel), 32'hFFFF, "reload held");
                mask_w = 32'h100;
            end
        end
        wr(OFF_KEY, {24'h0, KEY_LOCK}, 4'h1);
        wr(OFF_CTRL, 32'h0, 4'hF);
        rd(OFF_CTRL, {26'h0, op, 1'b1, 3'h7}, 32'h3F, "relocked");
        rd(OFF_STAT, 32'h0, 32'h4, "lock state");
        summarize();
    end
endmodule
`default_nettype wire
